// file: design/bsfc_cfg.svh
/*
 Constants for the backup supervisor and fault control block: timing figures,
 derived cycle counts and the APB register map.
 Assumes a 25 MHz block clock; includers use the macros by name.
*/
// Operation
// - Filter 5.5%/9% comparators: rise 6us, fall 2us
// - Filter boost comparator: rise 6us, fall 20us
// - Rail above -5.5% in backup ends boost, recharges
// - Main sense above backup rail ends backup
// - Backup indicator drives external pass switch
// - Boost stops only at cycle end; the code stops it at once on a fault or lockout
// - Overload keeps issuing high-current pulses
// - Rail below -9% over 7.5us: lockout
// - Resets stay valid down to 1V
// - Cell below 0.9V over 20us in backup: lockout
// - Low-cell lockout only between 0.25V and 0.9V
// - Cell below 0.25V for 2s: lockout
// - Low-cell warning when cell below 1V
// - Warning forced off during trickle charge
// - Charge phase limited to 14us
// - Discharge phase limited to 10us
// - Over-temperature forces lockout
// - Rail below -7% enters backup, boost on
// - Resets held 200ms after recovery threshold
`ifndef BSFC_CFG_SVH
`define BSFC_CFG_SVH

// ==========================================================================
// Timing
// ==========================================================================
`define BSFC_CLK_HZ         25000000
`define BSFC_T_RISE_NS      6000
`define BSFC_T_FALL_NS      2000
`define BSFC_T_BFALL_NS     20000
`define BSFC_T_UV_NS        7500
`define BSFC_T_CELL_NS      20000
`define BSFC_T_CHG_NS       14000
`define BSFC_T_DIS_NS       10000
`define BSFC_T_HARD_MS      2000
`define BSFC_T_HOLD_MS      200
`define BSFC_CYC_NS         (1000000000 / `BSFC_CLK_HZ)
`define BSFC_CYC_UP(ns)     (((ns) + `BSFC_CYC_NS - 1) / `BSFC_CYC_NS)
`define BSFC_CYC_DN(ns)     ((ns) / `BSFC_CYC_NS)
`define BSFC_N_RISE         `BSFC_CYC_UP(`BSFC_T_RISE_NS)
`define BSFC_N_FALL         `BSFC_CYC_UP(`BSFC_T_FALL_NS)
`define BSFC_N_BFALL        `BSFC_CYC_UP(`BSFC_T_BFALL_NS)
`define BSFC_N_UV           `BSFC_CYC_UP(`BSFC_T_UV_NS)
`define BSFC_N_CELL         `BSFC_CYC_UP(`BSFC_T_CELL_NS)
`define BSFC_N_CHG          `BSFC_CYC_DN(`BSFC_T_CHG_NS)
`define BSFC_N_DIS          `BSFC_CYC_DN(`BSFC_T_DIS_NS)
`define BSFC_N_HARD         (`BSFC_T_HARD_MS * (`BSFC_CLK_HZ / 1000))
`define BSFC_N_HOLD         (`BSFC_T_HOLD_MS * (`BSFC_CLK_HZ / 1000))

// ==========================================================================
// Register map (byte addresses)
// ==========================================================================
`define BSFC_ADDR_CTRL      12'h000
`define BSFC_ADDR_STATUS    12'h004
`define BSFC_CTRL_RESET     32'h00000001
`define BSFC_CTRL_USE_PS    0
`define BSFC_CTRL_TRICKLE   1

`endif

// file: design/bsfc_pkg.sv
/*
 Types for the backup supervisor and fault control block.
 Assumes bsfc_cfg.svh for numeric constants.
*/
package bsfc_pkg;

   // Raw comparator outputs from the analog front end
   typedef struct packed {
      logic rail_ok;      // Rail above rated minus 5.5%
      logic rail_boost;   // Rail above rated minus 7%
      logic rail_uv_ok;   // Rail above rated minus 9%
      logic rail_alive;   // Rail above 1V
      logic main_above;   // Main sense above backup rail plus 2.5%
      logic cell_lt_0v9;  // Cell sense below 0.9V
      logic cell_lt_0v25; // Cell sense below 0.25V
      logic cell_lt_1v;   // Cell voltage below 1V
      logic over_temp;    // Die over 155 C
      logic ind_peak;     // Inductor current reached its limit
      logic ind_zero;     // Inductor current back at zero
   } bsfc_cmp_t;

   typedef enum logic [3:0] {
      BSFC_NORMAL = 4'b0001,
      BSFC_BACKUP = 4'b0010,
      BSFC_LOCK   = 4'b0100,
      BSFC_HOLD   = 4'b1000
   } bsfc_mode_t;

   typedef enum logic [2:0] {
      BSFC_SW_IDLE   = 3'b001,
      BSFC_SW_CHARGE = 3'b010,
      BSFC_SW_DISCH  = 3'b100
   } bsfc_sw_t;

endpackage : bsfc_pkg

// file: design/bsfc_filter.sv
/*
 Asymmetric delay filter: the output follows the input only after the input
 has held its new level for the rise or fall count.
 Assumes the input is already synchronous to clock.
*/
`timescale 1ns/10ps
`default_nettype none
module bsfc_filter
#(
   parameter int RISE_N = 150,
   parameter int FALL_N = 50,
   parameter int W      = 10
)
(
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // Level
   input  wire logic din,
   output var  logic dout
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic         out_q;
   logic         out_d;

   always_comb
   begin
      cnt_d = '0;
      out_d = out_q;
      if (din != out_q)
      begin
         cnt_d = cnt_q + W'(1);
         if (cnt_q >= (din ? W'(RISE_N - 1) : W'(FALL_N - 1)))
         begin
            out_d = din;
            cnt_d = '0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q <= '0;
         out_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         out_q <= out_d;
      end
   end

   assign dout = out_q;
endmodule : bsfc_filter
`default_nettype wire

// file: design/bsfc_top.sv
/*
 Supervisor and fault control of a single-cell backup supply: comparator
 filtering, backup entry and exit, boost switch timing, lockout and resets.
 Assumes analog comparators arrive asynchronously and an APB master on clock.
*/
// Local design decisions: the register addresses and the APB register port.
`include "bsfc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module bsfc_top
   import bsfc_pkg::*;
#(
   parameter int HARD_N = `BSFC_N_HARD,
   parameter int HOLD_N = `BSFC_N_HOLD
)
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // Analog comparators
   input  wire bsfc_cmp_t   cmp_in,
   // Controls
   output var  logic        backup_n,
   output var  logic        boost_low_on,
   output var  logic        boost_high_on,
   output var  logic        high_current,
   output var  logic        recharge,
   output var  logic        undervoltage_lockout,
   output var  logic        reset_out,
   output var  logic        reset_out_n,
   output var  logic        low_cell_warning
);
   // =======================================================================
   // Input synchronisers
   // =======================================================================
   bsfc_cmp_t s1_q;
   bsfc_cmp_t s2_q;
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_q <= '0;
         s2_q <= '0;
      end
      else
      begin
         s1_q <= cmp_in;
         s2_q <= s1_q;
      end
   end

   // =======================================================================
   // Comparator filters
   // =======================================================================
   logic f_ok;
   logic f_boost;
   logic f_uvok;
   bsfc_filter #(.RISE_N(`BSFC_N_RISE), .FALL_N(`BSFC_N_FALL), .W(10)) u_ok
   (
      .clock (clock),
      .rst_n (rst_n),
      .din   (s2_q.rail_ok),
      .dout  (f_ok)
   );
   bsfc_filter #(.RISE_N(`BSFC_N_RISE), .FALL_N(`BSFC_N_FALL), .W(10)) u_uv
   (
      .clock (clock),
      .rst_n (rst_n),
      .din   (s2_q.rail_uv_ok),
      .dout  (f_uvok)
   );
   bsfc_filter #(.RISE_N(`BSFC_N_RISE), .FALL_N(`BSFC_N_BFALL), .W(10)) u_bst
   (
      .clock (clock),
      .rst_n (rst_n),
      .din   (s2_q.rail_boost),
      .dout  (f_boost)
   );

   // =======================================================================
   // APB registers
   // =======================================================================
   logic [1:0] ctrl_q;
   logic [1:0] ctrl_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic        rdy_q;
   logic        rdy_d;
   logic        err_q;
   logic        err_d;
   bsfc_mode_t  mode_q;
   bsfc_mode_t  mode_d;
   bsfc_sw_t    sw_q;
   bsfc_sw_t    sw_d;

   wire use_ps  = ctrl_q[`BSFC_CTRL_USE_PS];
   wire trickle = ctrl_q[`BSFC_CTRL_TRICKLE];
   wire setup   = psel && !penable && !rdy_q;

   always_comb
   begin
      ctrl_d  = ctrl_q;
      rdata_d = rdata_q;
      rdy_d   = 1'b0;
      err_d   = 1'b0;
      if (setup)
      begin
         rdy_d = 1'b1;
         if (paddr == `BSFC_ADDR_CTRL)
         begin
            rdata_d = {30'h0, ctrl_q};
         end
         else if (paddr == `BSFC_ADDR_STATUS)
         begin
            rdata_d = {21'h0, boost_high_on, boost_low_on, high_current,
                       low_cell_warning, reset_out, undervoltage_lockout, !backup_n, mode_q};
         end
         else
         begin
            err_d   = 1'b1;
            rdata_d = 32'h00000000;
         end
         if (pwrite)
            rdata_d = 32'h00000000;
      end
      // A write lands only at the access edge, where pready is sampled high
      if (psel && penable && rdy_q && pwrite && (paddr == `BSFC_ADDR_CTRL))
         ctrl_d = pwdata[1:0];
   end

   // =======================================================================
   // Fault timers and mode machine
   // =======================================================================
   logic [9:0]  uv_cnt_q;
   logic [9:0]  uv_cnt_d;
   logic [9:0]  cell_cnt_q;
   logic [9:0]  cell_cnt_d;
   logic [31:0] long_cnt_q;
   logic [31:0] long_cnt_d;
   logic [31:0] hold_cnt_q;
   logic [31:0] hold_cnt_d;
   logic        boost_en;
   logic        fault;

   wire in_backup = (mode_q == BSFC_BACKUP);
   wire low_band  = s2_q.cell_lt_0v9 && !s2_q.cell_lt_0v25;

   always_comb
   begin
      uv_cnt_d   = 10'h000;
      cell_cnt_d = 10'h000;
      long_cnt_d = 32'h00000000;
      if (!f_uvok && (mode_q != BSFC_LOCK))
         uv_cnt_d = (uv_cnt_q == 10'h3FF) ? uv_cnt_q : uv_cnt_q + 10'h001;
      if (in_backup && low_band)
         cell_cnt_d = (cell_cnt_q == 10'h3FF) ? cell_cnt_q : cell_cnt_q + 10'h001;
      if (s2_q.cell_lt_0v25 && (mode_q != BSFC_LOCK))
         long_cnt_d = long_cnt_q + 32'h00000001;
      fault = (uv_cnt_q >= 10'(`BSFC_N_UV))
            || (cell_cnt_q >= 10'(`BSFC_N_CELL))
            || (long_cnt_q >= 32'(HARD_N))
            || s2_q.over_temp;
   end

   always_comb
   begin
      mode_d     = mode_q;
      hold_cnt_d = 32'h00000000;
      case (mode_q)
         BSFC_NORMAL:
         begin
            if (fault)
               mode_d = BSFC_LOCK;
            else if (!f_boost)
               mode_d = BSFC_BACKUP;
         end
         BSFC_BACKUP:
         begin
            if (fault)
               mode_d = BSFC_LOCK;
            else if (f_ok || (use_ps && s2_q.main_above))
               mode_d = BSFC_NORMAL;
         end
         BSFC_LOCK:
         begin
            if (f_ok && !s2_q.over_temp)
               mode_d = BSFC_HOLD;
         end
         BSFC_HOLD:
         begin
            hold_cnt_d = hold_cnt_q + 32'h00000001;
            if (!f_ok || s2_q.over_temp)
               mode_d = BSFC_LOCK;
            else if (hold_cnt_q >= 32'(HOLD_N - 1))
               mode_d = BSFC_NORMAL;
         end
         default:
            mode_d = BSFC_LOCK;
      endcase
   end

   // =======================================================================
   // Boost switch sequencing
   // =======================================================================
   logic [9:0] ph_cnt_q;
   logic [9:0] ph_cnt_d;
   logic [1:0] pulse_q;
   logic [1:0] pulse_d;
   logic       hi_q;
   logic       hi_d;

   // Boost runs only in backup below the filtered boost threshold
   assign boost_en = in_backup && !f_boost && !fault;

   always_comb
   begin
      sw_d     = sw_q;
      ph_cnt_d = ph_cnt_q + 10'h001;
      pulse_d  = pulse_q;
      hi_d     = hi_q;
      case (sw_q)
         BSFC_SW_IDLE:
         begin
            ph_cnt_d = 10'h000;
            if (f_boost || !in_backup)
            begin
               pulse_d = 2'b00;
               hi_d    = 1'b0;
            end
            if (boost_en)
               sw_d = BSFC_SW_CHARGE;
         end
         BSFC_SW_CHARGE:
         begin
            // Charge limit keeps switching at reduced output
            if (s2_q.ind_peak || (ph_cnt_q >= 10'(`BSFC_N_CHG - 1)))
            begin
               sw_d     = BSFC_SW_DISCH;
               ph_cnt_d = 10'h000;
            end
         end
         BSFC_SW_DISCH:
         begin
            // A cycle completes unless a fault or lockout cuts it short, so no energy is left in the inductor
            if (s2_q.ind_zero || (ph_cnt_q >= 10'(`BSFC_N_DIS - 1)))
            begin
               ph_cnt_d = 10'h000;
               if (pulse_q != 2'b10)
                  pulse_d = pulse_q + 2'b01;
               if (pulse_q == 2'b01)
                  hi_d = 1'b1;
               sw_d = boost_en ? BSFC_SW_CHARGE : BSFC_SW_IDLE;
            end
         end
         default:
            sw_d = BSFC_SW_IDLE;
      endcase
      // Lockout stops the switches at once; any other end of boost waits for the cycle end
      if (fault || (mode_q == BSFC_LOCK))
      begin
         sw_d     = BSFC_SW_IDLE;
         ph_cnt_d = 10'h000;
      end
   end

   // =======================================================================
   // State registers and outputs
   // =======================================================================
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_q     <= 2'(`BSFC_CTRL_RESET);
         rdata_q    <= 32'h00000000;
         rdy_q      <= 1'b0;
         err_q      <= 1'b0;
         mode_q     <= BSFC_LOCK;
         sw_q       <= BSFC_SW_IDLE;
         uv_cnt_q   <= 10'h000;
         cell_cnt_q <= 10'h000;
         long_cnt_q <= 32'h00000000;
         hold_cnt_q <= 32'h00000000;
         ph_cnt_q   <= 10'h000;
         pulse_q    <= 2'b00;
         hi_q       <= 1'b0;
         backup_n             <= 1'b1;
         boost_low_on         <= 1'b0;
         boost_high_on        <= 1'b0;
         high_current         <= 1'b0;
         recharge             <= 1'b0;
         undervoltage_lockout <= 1'b1;
         reset_out            <= 1'b1;
         reset_out_n          <= 1'b0;
         low_cell_warning     <= 1'b0;
      end
      else
      begin
         ctrl_q     <= ctrl_d;
         rdata_q    <= rdata_d;
         rdy_q      <= rdy_d;
         err_q      <= err_d;
         mode_q     <= mode_d;
         sw_q       <= sw_d;
         uv_cnt_q   <= uv_cnt_d;
         cell_cnt_q <= cell_cnt_d;
         long_cnt_q <= long_cnt_d;
         hold_cnt_q <= hold_cnt_d;
         ph_cnt_q   <= ph_cnt_d;
         pulse_q    <= pulse_d;
         hi_q       <= hi_d;
         // Low-going indicator also gates the external pass switch on
         backup_n             <= (mode_d != BSFC_BACKUP);
         boost_low_on         <= (sw_d == BSFC_SW_CHARGE);
         boost_high_on        <= (sw_d == BSFC_SW_DISCH);
         high_current         <= hi_d;
         recharge             <= (mode_q == BSFC_BACKUP) && (mode_d == BSFC_NORMAL);
         undervoltage_lockout <= (mode_d == BSFC_LOCK);
         // Resets held through lockout and hold; the logic runs down to 1V
         reset_out            <= (mode_d == BSFC_LOCK) || (mode_d == BSFC_HOLD);
         reset_out_n          <= !((mode_d == BSFC_LOCK) || (mode_d == BSFC_HOLD));
         low_cell_warning     <= s2_q.cell_lt_1v && !trickle;
      end
   end

   assign prdata  = rdata_q;
   assign pready  = rdy_q;
   assign pslverr = err_q;
endmodule : bsfc_top
`default_nettype wire

// file: tb/bsfc_partner.sv
/*
 Far-side model: inductor current comparators and the host's reset reaction.
 Assumes switch drives come straight from bsfc_top.
*/
`timescale 1ns/10ps
`default_nettype none
module bsfc_partner
#(
   parameter int PEAK = 20
)
(
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // From the block
   input  wire logic low_on,
   input  wire logic high_on,
   input  wire logic reset_out,
   // To the block and the bench
   output var  logic ind_peak,
   output var  logic ind_zero,
   output var  logic host_halted
);
   // ==========================================================
   // Inductor level
   // ==========================================================
   int   lvl_q;
   int   lvl_d;
   logic halt_q;
   logic halt_d;
   always_comb
   begin
      lvl_d = lvl_q;
      if (low_on && lvl_q < PEAK)
         lvl_d = lvl_q + 1;
      // With the low switch off the current always runs down, switched or not
      else if (!low_on && lvl_q > 0)
         lvl_d = lvl_q - 1;
      // Host parks itself while reset is high
      halt_d = reset_out;
   end
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
         {lvl_q, halt_q} <= '0;
      else
         {lvl_q, halt_q} <= {lvl_d, halt_d};
   assign ind_peak    = (lvl_q >= PEAK);
   assign ind_zero    = (lvl_q == 0);
   assign host_halted = halt_q;
endmodule : bsfc_partner
`default_nettype wire

// file: tb/bsfc_checker.sv
/*
 Port assertions for bsfc_top.
 Assumes one clock domain and an active-low asynchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
module bsfc_checker
   import bsfc_pkg::*;
(
   // Clock, reset and bus
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   // Comparators and controls
   input wire bsfc_cmp_t   cmp_in,
   input wire logic        boost_low_on,
   input wire logic        boost_high_on,
   input wire logic        undervoltage_lockout,
   input wire logic        reset_out,
   input wire logic        reset_out_n,
   input wire logic        low_cell_warning
);
   // ==========================================================
   // Switch on-time counters
   // ==========================================================
   int lo_q;
   int lo_d;
   int hi_q;
   int hi_d;
   always_comb
   begin
      lo_d = boost_low_on ? lo_q + 1 : 0;
      hi_d = boost_high_on ? hi_q + 1 : 0;
   end
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
         {lo_q, hi_q} <= '0;
      else
         {lo_q, hi_q} <= {lo_d, hi_d};
   // ==========================================================
   // Properties
   // ==========================================================
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_cell_good;
      !cmp_in.cell_lt_1v [*4];
   endsequence
   a_ready_follows: assert property (s_setup |=> pready)
      else $error("pready missing after setup");
   a_unmapped_err: assert property (s_setup |=> pslverr == !($past(paddr) == 12'h000 || $past(paddr) == 12'h004))
      else $error("pslverr does not match address");
   a_reset_pair: assert property (reset_out != reset_out_n)
      else $error("reset outputs disagree");
   a_lock_resets: assert property (undervoltage_lockout |-> reset_out)
      else $error("lockout without reset");
   a_lock_idle: assert property (undervoltage_lockout [*3] |-> !boost_low_on && !boost_high_on)
      else $error("switch on in lockout");
   a_temp_lock: assert property (cmp_in.over_temp [*3] |-> ##[1:6] undervoltage_lockout)
      else $error("no lockout on over-temperature");
   a_warn_clear: assert property (s_cell_good |=> !low_cell_warning)
      else $error("warning with cell good");
   a_charge_limit: assert property (lo_q <= 350)
      else $error("charge phase too long");
   a_disch_limit: assert property (hi_q <= 250)
      else $error("discharge phase too long");
endmodule : bsfc_checker
bind bsfc_top bsfc_checker bsfc_checker_i (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
   .paddr(paddr), .pready(pready), .pslverr(pslverr), .cmp_in(cmp_in), .boost_low_on(boost_low_on),
   .boost_high_on(boost_high_on), .undervoltage_lockout(undervoltage_lockout), .reset_out(reset_out),
   .reset_out_n(reset_out_n), .low_cell_warning(low_cell_warning));
`default_nettype wire

// file: tb/bsfc_top_tb.sv
/*
 Self-checking bench for bsfc_top, one task per scenario.
 Assumes the partner model closes the inductor current loop.
*/
`timescale 1ns/10ps
`default_nettype none
module bsfc_top_tb;
   import bsfc_pkg::*;
   logic        clock = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, rd;
   logic        pready, pslverr, er, backup_n, boost_low_on, boost_high_on, high_current, recharge;
   logic        undervoltage_lockout, reset_out, reset_out_n, low_cell_warning, ind_pk, ind_zr;
   logic        host_halted, stall = 1'h0;
   bsfc_cmp_t   cmp_tb = 11'h780;
   bsfc_cmp_t   cmp_w;
   int          failures = 0, total_checks = 0, n;
   assign cmp_w = {cmp_tb[10:2], ind_pk && !stall, ind_zr && !stall};
   always #20 clock = ~clock;
   bsfc_top #(.HARD_N(200), .HOLD_N(100)) bsfc_top_i (.clock(clock), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmp_in(cmp_w), .backup_n(backup_n), .boost_low_on(boost_low_on),
      .boost_high_on(boost_high_on), .high_current(high_current), .recharge(recharge),
      .undervoltage_lockout(undervoltage_lockout), .reset_out(reset_out), .reset_out_n(reset_out_n),
      .low_cell_warning(low_cell_warning));
   bsfc_partner bsfc_partner_i (.clock(clock), .rst_n(rst_n), .low_on(boost_low_on), .high_on(boost_high_on),
      .reset_out(reset_out), .ind_peak(ind_pk), .ind_zero(ind_zr), .host_halted(host_halted));
   // ==========================================================
   // Shared tasks
   // ==========================================================
   task conclude;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   task chk(input logic [31:0] a, input logic [31:0] e);
      total_checks++;
      if (a !== e)
      begin
         failures++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e);
      end
   endtask : chk
   function automatic logic sig(input int s);
      case (s)
         0: return backup_n;
         1: return undervoltage_lockout;
         2: return reset_out;
         3: return low_cell_warning;
         4: return boost_low_on;
         5: return high_current;
         6: return boost_high_on;
         default: return recharge;
      endcase
   endfunction : sig
   // Polls just after each edge so registered outputs have settled
   task automatic wt(input int s, input logic v, input int lim, output int cnt);
      cnt = 0;
      while (sig(s) !== v && cnt < lim)
      begin
         @(posedge clock);
         #1;
         cnt++;
      end
      total_checks++;
      if (cnt >= lim)
      begin
         failures++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, sig(s), v);
         conclude();
      end
   endtask : wt
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      @(posedge clock);
      {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, wr, a, wd};
      @(posedge clock);
      penable <= 1'h1;
      // Read at the edge itself, before that edge's register updates land
      do
      begin
         @(posedge clock);
         k++;
      end
      while (pready !== 1'h1 && k < 20);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'h0;
      if (pready !== 1'h1)
      begin
         failures++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, pready, 1'h1);
         conclude();
      end
   endtask : apb
   task automatic enter_backup;
      @(posedge clock);
      {cmp_tb.rail_ok, cmp_tb.rail_boost} <= 2'h0;
      wt(0, 1'h0, 700, n);
      chk(32'(n >= 500), 32'h1);
   endtask : enter_backup
   task automatic recover;
      @(posedge clock);
      cmp_tb <= 11'h780;
      wt(2, 1'h0, 800, n);
   endtask : recover
   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_power;
      wt(2, 1'h0, 800, n);
      chk(32'(n >= 250), 32'h1);
      chk(32'(undervoltage_lockout), 32'h0);
   endtask : t_power
   task automatic t_regs;
      apb(1'h0, 12'h000, 32'h00000000);
      chk(rd, 32'h00000001);
      apb(1'h1, 12'h004, 32'hFFFFFFFF);
      apb(1'h0, 12'h004, 32'h00000000);
      chk(32'(rd[6:0]), 32'h00000001);
      apb(1'h1, 12'h008, 32'hFFFFFFFF);
      chk(32'(er), 32'h1);
      apb(1'h0, 12'h008, 32'h00000000);
      chk({rd[30:0], er}, 32'h1);
   endtask : t_regs
   task automatic t_backup;
      enter_backup();
      wt(4, 1'h1, 20, n);
      wt(5, 1'h1, 300, n);
      // Masked current sense lets both phase timers run out
      @(posedge clock);
      stall <= 1'h1;
      wt(4, 1'h0, 400, n);
      wt(6, 1'h0, 300, n);
      chk(n, 32'h000000FA);
      wt(4, 1'h0, 400, n);
      chk(n, 32'h0000015E);
      @(posedge clock);
      stall <= 1'h0;
      {cmp_tb.rail_ok, cmp_tb.rail_boost} <= 2'h3;
      wt(7, 1'h1, 400, n);
      chk(32'(n >= 150), 32'h1);
      wt(0, 1'h1, 3, n);
      wt(4, 1'h0, 60, n);
      wt(6, 1'h0, 60, n);
      chk(32'({boost_low_on, boost_high_on}), 32'h0);
   endtask : t_backup
   task automatic t_main;
      enter_backup();
      apb(1'h1, 12'h000, 32'h00000000);
      // Rail held low, so only the sense path can end backup
      @(posedge clock);
      cmp_tb <= 11'h1C0;
      repeat (60) @(posedge clock);
      #1;
      chk(32'(backup_n), 32'h0);
      apb(1'h1, 12'h000, 32'h00000001);
      wt(0, 1'h1, 10, n);
      @(posedge clock);
      cmp_tb <= 11'h780;
      repeat (400) @(posedge clock);
   endtask : t_main
   task automatic t_cell;
      enter_backup();
      @(posedge clock);
      {cmp_tb.cell_lt_0v9, cmp_tb.cell_lt_0v25} <= 2'h3;
      repeat (150) @(posedge clock);
      #1;
      chk(32'(undervoltage_lockout), 32'h0);
      @(posedge clock);
      cmp_tb.cell_lt_0v25 <= 1'h0;
      wt(1, 1'h1, 600, n);
      chk(32'(n >= 500), 32'h1);
      recover();
   endtask : t_cell
   task automatic t_hard;
      @(posedge clock);
      {cmp_tb.cell_lt_0v9, cmp_tb.cell_lt_0v25} <= 2'h3;
      wt(1, 1'h1, 400, n);
      chk(32'(n >= 200), 32'h1);
      recover();
   endtask : t_hard
   task automatic t_uv;
      enter_backup();
      @(posedge clock);
      cmp_tb.rail_uv_ok <= 1'h0;
      wt(1, 1'h1, 400, n);
      chk(32'(n >= 238), 32'h1);
      chk(32'(reset_out), 32'h1);
      @(posedge clock);
      #1;
      chk(32'(host_halted), 32'h1);
      recover();
      @(posedge clock);
      cmp_tb.over_temp <= 1'h1;
      wt(1, 1'h1, 10, n);
      recover();
   endtask : t_uv
   task automatic t_warn;
      @(posedge clock);
      cmp_tb.cell_lt_1v <= 1'h1;
      wt(3, 1'h1, 10, n);
      apb(1'h1, 12'h000, 32'h00000003);
      wt(3, 1'h0, 10, n);
      apb(1'h1, 12'h000, 32'h00000001);
      wt(3, 1'h1, 10, n);
      @(posedge clock);
      cmp_tb.cell_lt_1v <= 1'h0;
   endtask : t_warn
   initial
   begin
      repeat (10) @(posedge clock);
      rst_n <= 1'h1;
      t_power();
      t_regs();
      t_backup();
      t_main();
      t_cell();
      t_hard();
      t_uv();
      t_warn();
      conclude();
   end
endmodule : bsfc_top_tb
`default_nettype wire
